// ==== verilog/tted_consts.svh ====
// register offsets, reset values and timing counts of the trigger path
`ifndef TTED_CONSTS_SVH
`define TTED_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TTED_CTRL_OFF     12'h000
`define TTED_FILT_OFF     12'h004
`define TTED_TRIGDLY_OFF  12'h008
`define TTED_EXPDLY_OFF   12'h00C
`define TTED_EXPTIME_OFF  12'h010
`define TTED_ALIGN_OFF    12'h014
`define TTED_STATUS_OFF   12'h018
`define TTED_IRQ_OFF      12'h01C
`define TTED_MASK_OFF     12'h020
`define TTED_SWTRIG_OFF   12'h024

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TTED_CTRL_EN_BIT     0
`define TTED_CTRL_SWSRC_BIT  1
`define TTED_CTRL_FALL_BIT   2
`define TTED_IRQ_COLL_BIT    0
`define TTED_IRQ_EXPST_BIT   1
`define TTED_IRQ_EXPEND_BIT  2
`define TTED_IRQ_W           3

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define TTED_CTRL_RST     3'h1
`define TTED_EXPDLY_MAX   16'd5000
`define TTED_EXPDLY_MIN   16'd0
`define TTED_EXPTIME_RST  24'd1000
`define TTED_ALIGN_RST    16'd0

// ----------------------------------------------------------------
// timing: one microsecond tick derived from the core clock
// ----------------------------------------------------------------
`define TTED_CLK_MHZ      100
`define TTED_US_NS        1000
`define TTED_CLK_NS       10
`define TTED_US_CYC       (`TTED_US_NS / `TTED_CLK_NS)

`endif

// ==== verilog/tted_pkg.sv ====
// types shared by the trigger-to-exposure design files
package tted_pkg;
   typedef enum logic [2:0] {
      TTED_IDLE   = 3'b000,
      TTED_FILT   = 3'b001,
      TTED_HOLD   = 3'b011,
      TTED_LEAD   = 3'b010,
      TTED_ALIGN  = 3'b110,
      TTED_EXPOSE = 3'b111
   } tted_state_t;
endpackage

// ==== verilog/tted_us_cnt.sv ====
// microsecond down-counter: load, count on ticks, flag at zero
`timescale 1ns/100ps
module tted_us_cnt #(
   parameter int W = 16
) (
   input wire logic core_clk, // core clock
   input wire logic arst_n, // async reset
   input wire logic load, // load start value
   input wire logic [W-1:0] load_val, // value in microseconds
   input wire logic us_tick, // one-microsecond tick
   output logic done // count reached zero
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic skip_r;
   logic skip_nxt;

   // the tick runs free, so the first one after a load is partial;
   // skipping it makes a stage late by under a microsecond, never early
   always_comb begin
      cnt_nxt = cnt_r;
      skip_nxt = skip_r;
      if (load) begin
         cnt_nxt = load_val;
         skip_nxt = 1'b1;
      end else if (us_tick && skip_r) begin
         skip_nxt = 1'b0;
      end else if (us_tick && cnt_r != '0) begin
         cnt_nxt = cnt_r - W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         skip_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         skip_r <= skip_nxt;
      end
   end

   assign done = (cnt_r == '0) && !load;
endmodule

// ==== verilog/tted_in_filt.sv ====
// trigger input synchroniser and glitch filter in microsecond steps
`timescale 1ns/100ps
module tted_in_filt #(
   parameter int W = 16
) (
   input wire logic core_clk, // core clock
   input wire logic arst_n, // async reset
   input wire logic pin_in, // raw trigger pin
   input wire logic us_tick, // one-microsecond tick
   input wire logic [W-1:0] filt_us, // filter time in microseconds
   output logic level // filtered level
);
   logic sync1_r;
   logic sync2_r;
   logic level_r;
   logic level_nxt;
   logic [W-1:0] stab_r;
   logic [W-1:0] stab_nxt;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
      end
   end

   // any return to the old level restarts the stability count
   always_comb begin
      level_nxt = level_r;
      stab_nxt = stab_r;
      if (sync2_r == level_r) begin
         stab_nxt = '0;
      // one tick beyond the setting: the free tick may land early
      end else if (filt_us == '0 || stab_r > filt_us) begin
         level_nxt = sync2_r;
         stab_nxt = '0;
      end else if (us_tick) begin
         stab_nxt = stab_r + W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_r <= 1'b0;
         stab_r <= '0;
      end else begin
         level_r <= level_nxt;
         stab_r <= stab_nxt;
      end
   end

   assign level = level_r;
endmodule

// ==== verilog/tted_top.sv ====
// trigger-to-exposure timing path with apb registers and interrupt
`timescale 1ns/100ps
`include "tted_consts.svh"

module tted_top (
   input wire logic core_clk, // 100 MHz core clock
   input wire logic arst_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic trig_pin, // external trigger pin
   input wire logic row_start, // sensor row boundary pulse
   output logic strobe_out, // strobe light output
   output logic expose_out, // sensor exposure active
   output tted_pkg::tted_state_t state_out, // path state
   output logic frame_start_collision_event, // collision pulse
   output logic irq // level interrupt
);
   import tted_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [2:0] ctrl_r, ctrl_nxt;
   logic [15:0] filt_r, filt_nxt;
   logic [15:0] trigdly_r, trigdly_nxt;
   logic [15:0] expdly_r, expdly_nxt;
   logic [23:0] exptime_r, exptime_nxt;
   logic [15:0] align_r, align_nxt;
   logic [`TTED_IRQ_W-1:0] irq_r, irq_nxt;
   logic [`TTED_IRQ_W-1:0] mask_r, mask_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic sw_trig_r, sw_trig_nxt;
   logic wr_acc, rd_acc, hit;

   // ----------------------------------------------------------------
   // path state
   // ----------------------------------------------------------------
   tted_state_t st_r, st_nxt;
   logic strobe_r, strobe_nxt;
   logic expose_r, expose_nxt;
   logic coll_r, coll_nxt;
   logic [6:0] div_r, div_nxt;
   logic us_tick;
   logic row1_r, row2_r, row3_r;
   logic row_edge;
   logic filt_level, filt_prev_r;
   logic hw_edge, trig_evt;
   logic ld_hold, ld_lead, ld_align, ld_exp;
   logic hold_done, lead_done, align_done, exp_done;
   logic exp_start, exp_end;

   // single-cycle apb answer: pready high in every access phase
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign pready = psel && penable;

   always_comb begin
      hit = 1'b1;
      case (paddr)
         `TTED_CTRL_OFF, `TTED_FILT_OFF, `TTED_TRIGDLY_OFF,
         `TTED_EXPDLY_OFF, `TTED_EXPTIME_OFF, `TTED_ALIGN_OFF,
         `TTED_STATUS_OFF, `TTED_IRQ_OFF, `TTED_MASK_OFF,
         `TTED_SWTRIG_OFF: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = pready && !hit;

   // ----------------------------------------------------------------
   // register writes and reads
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      filt_nxt = filt_r;
      trigdly_nxt = trigdly_r;
      expdly_nxt = expdly_r;
      exptime_nxt = exptime_r;
      align_nxt = align_r;
      mask_nxt = mask_r;
      sw_trig_nxt = 1'b0;
      irq_nxt = irq_r;
      prdata_nxt = prdata_r;
      if (wr_acc) begin
         case (paddr)
            `TTED_CTRL_OFF: ctrl_nxt = pwdata[2:0];
            `TTED_FILT_OFF: filt_nxt = pwdata[15:0];
            `TTED_TRIGDLY_OFF: trigdly_nxt = pwdata[15:0];
            `TTED_EXPDLY_OFF: begin
               // out-of-range writes saturate at the top value
               if (pwdata[15:0] > `TTED_EXPDLY_MAX || |pwdata[31:16]) begin
                  expdly_nxt = `TTED_EXPDLY_MAX;
               end else begin
                  expdly_nxt = pwdata[15:0];
               end
            end
            `TTED_EXPTIME_OFF: exptime_nxt = pwdata[23:0];
            `TTED_ALIGN_OFF: align_nxt = pwdata[15:0];
            `TTED_IRQ_OFF: irq_nxt = irq_r & ~pwdata[`TTED_IRQ_W-1:0];
            `TTED_MASK_OFF: mask_nxt = pwdata[`TTED_IRQ_W-1:0];
            `TTED_SWTRIG_OFF: sw_trig_nxt = pwdata[0];
            default: ;
         endcase
      end
      // set wins over a clear in the same cycle
      irq_nxt[`TTED_IRQ_COLL_BIT] = irq_nxt[`TTED_IRQ_COLL_BIT] | coll_nxt;
      irq_nxt[`TTED_IRQ_EXPST_BIT] = irq_nxt[`TTED_IRQ_EXPST_BIT] | exp_start;
      irq_nxt[`TTED_IRQ_EXPEND_BIT] = irq_nxt[`TTED_IRQ_EXPEND_BIT] | exp_end;
      if (rd_acc) begin
         case (paddr)
            `TTED_CTRL_OFF: prdata_nxt = {29'h0, ctrl_r};
            `TTED_FILT_OFF: prdata_nxt = {16'h0, filt_r};
            `TTED_TRIGDLY_OFF: prdata_nxt = {16'h0, trigdly_r};
            `TTED_EXPDLY_OFF: prdata_nxt = {16'h0, expdly_r};
            `TTED_EXPTIME_OFF: prdata_nxt = {8'h0, exptime_r};
            `TTED_ALIGN_OFF: prdata_nxt = {16'h0, align_r};
            `TTED_STATUS_OFF:
               prdata_nxt = {27'h0, expose_r, strobe_r, st_r};
            `TTED_IRQ_OFF: prdata_nxt = {29'h0, irq_r};
            `TTED_MASK_OFF: prdata_nxt = {29'h0, mask_r};
            default: prdata_nxt = 32'h0;
         endcase
      end
   end

   // read data is passed straight through in the access phase, then held in prdata_r
   assign prdata = rd_acc ? prdata_nxt : prdata_r;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= `TTED_CTRL_RST;
         filt_r <= 16'h0;
         trigdly_r <= 16'h0;
         expdly_r <= `TTED_EXPDLY_MIN;
         exptime_r <= `TTED_EXPTIME_RST;
         align_r <= `TTED_ALIGN_RST;
         mask_r <= '0;
         irq_r <= '0;
         sw_trig_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         filt_r <= filt_nxt;
         trigdly_r <= trigdly_nxt;
         expdly_r <= expdly_nxt;
         exptime_r <= exptime_nxt;
         align_r <= align_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
         sw_trig_r <= sw_trig_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign irq = |(irq_r & mask_r);

   // ----------------------------------------------------------------
   // microsecond tick and row boundary sync
   // ----------------------------------------------------------------
   always_comb begin
      div_nxt = div_r + 7'd1;
      if (div_r == 7'(`TTED_US_CYC - 1)) begin
         div_nxt = 7'd0;
      end
   end
   assign us_tick = (div_r == 7'(`TTED_US_CYC - 1));

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= 7'd0;
         row1_r <= 1'b0;
         row2_r <= 1'b0;
         row3_r <= 1'b0;
         filt_prev_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         row1_r <= row_start;
         row2_r <= row1_r;
         row3_r <= row2_r;
         filt_prev_r <= filt_level;
      end
   end
   assign row_edge = row2_r && !row3_r;

   // ----------------------------------------------------------------
   // filter stage and trigger source
   // ----------------------------------------------------------------
   tted_in_filt #(.W(16)) u_filt (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .pin_in(trig_pin),
      .us_tick(us_tick),
      .filt_us(filt_r),
      .level(filt_level)
   );

   assign hw_edge = ctrl_r[`TTED_CTRL_FALL_BIT] ?
      (filt_prev_r && !filt_level) : (!filt_prev_r && filt_level);
   assign trig_evt = ctrl_r[`TTED_CTRL_EN_BIT] &&
      (ctrl_r[`TTED_CTRL_SWSRC_BIT] ? sw_trig_r : hw_edge);

   // ----------------------------------------------------------------
   // stage timers
   // ----------------------------------------------------------------
   tted_us_cnt #(.W(16)) u_hold (
      .core_clk(core_clk), .arst_n(arst_n), .load(ld_hold),
      .load_val(trigdly_r), .us_tick(us_tick), .done(hold_done)
   );
   tted_us_cnt #(.W(16)) u_lead (
      .core_clk(core_clk), .arst_n(arst_n), .load(ld_lead),
      .load_val(expdly_r), .us_tick(us_tick), .done(lead_done)
   );
   tted_us_cnt #(.W(16)) u_align (
      .core_clk(core_clk), .arst_n(arst_n), .load(ld_align),
      .load_val(align_r), .us_tick(us_tick), .done(align_done)
   );
   tted_us_cnt #(.W(24)) u_exp (
      .core_clk(core_clk), .arst_n(arst_n), .load(ld_exp),
      .load_val(exptime_r), .us_tick(us_tick), .done(exp_done)
   );

   // ----------------------------------------------------------------
   // path sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      strobe_nxt = strobe_r;
      expose_nxt = expose_r;
      coll_nxt = 1'b0;
      ld_hold = 1'b0;
      ld_lead = 1'b0;
      ld_align = 1'b0;
      ld_exp = 1'b0;
      exp_start = 1'b0;
      exp_end = 1'b0;
      // trigger in any busy state is dropped and flagged
      if (trig_evt && st_r != TTED_IDLE) begin
         coll_nxt = 1'b1;
      end
      case (st_r)
         TTED_IDLE: begin
            if (trig_evt) begin
               st_nxt = TTED_HOLD;
               ld_hold = 1'b1;
            end
         end
         TTED_FILT: st_nxt = TTED_IDLE;
         TTED_HOLD: begin
            if (hold_done) begin
               st_nxt = TTED_LEAD;
               strobe_nxt = 1'b1;
               ld_lead = 1'b1;
            end
         end
         TTED_LEAD: begin
            if (lead_done) begin
               st_nxt = TTED_ALIGN;
               ld_align = 1'b1;
            end
         end
         TTED_ALIGN: begin
            // setup time counts, then first row boundary after it;
            // an edge seen during setup is not reused, start stays on a row
            if (align_done && row_edge) begin
               st_nxt = TTED_EXPOSE;
               expose_nxt = 1'b1;
               exp_start = 1'b1;
               ld_exp = 1'b1;
            end
         end
         TTED_EXPOSE: begin
            if (exp_done) begin
               st_nxt = TTED_IDLE;
               expose_nxt = 1'b0;
               strobe_nxt = 1'b0;
               exp_end = 1'b1;
            end
         end
         default: begin
            st_nxt = TTED_IDLE;
            strobe_nxt = 1'b0;
            expose_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= TTED_IDLE;
         strobe_r <= 1'b0;
         expose_r <= 1'b0;
         coll_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         strobe_r <= strobe_nxt;
         expose_r <= expose_nxt;
         coll_r <= coll_nxt;
      end
   end

   assign strobe_out = strobe_r;
   assign expose_out = expose_r;
   assign state_out = st_r;
   assign frame_start_collision_event = coll_r;
endmodule

// ==== dv/tted_properties.sv ====
// checker of the trigger path ports
`timescale 1ns/100ps
module tted_checker (
   input wire logic core_clk, // core clock
   input wire logic arst_n, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic trig_pin, // trigger pin
   input wire logic row_start, // row boundary
   input wire logic strobe_out, // strobe
   input wire logic expose_out, // exposure
   input wire tted_pkg::tted_state_t state_out, // path state
   input wire logic frame_start_collision_event, // collision pulse
   input wire logic irq // interrupt
);
   import tted_pkg::*;
   logic row_q_r;
   logic row_q_nxt;
   logic [7:0] row_age_r;
   logic [7:0] row_age_nxt;

   // ----------------------------------------------------------------
   // cycles since the last raw row edge
   // ----------------------------------------------------------------
   always_comb begin
      row_q_nxt = row_start;
      row_age_nxt = (row_age_r == 8'hFF) ? row_age_r : row_age_r + 8'h01;
      if (row_start && !row_q_r) begin
         row_age_nxt = 8'h00;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         row_q_r <= 1'b0;
         row_age_r <= 8'hFF;
      end else begin
         row_q_r <= row_q_nxt;
         row_age_r <= row_age_nxt;
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_apb_zero_wait: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_unmapped_err: assert property (psel && penable && !pwrite &&
      paddr > 12'h024 |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   a_strobe_first: assert property ($rose(expose_out) |-> strobe_out)
      else $error("exposure began without strobe");
   a_strobe_before: assert property ($rose(strobe_out) |-> !expose_out)
      else $error("strobe did not lead exposure");
   a_row_aligned: assert property ($rose(expose_out) |-> row_age_r <= 8'd12)
      else $error("exposure began off a row boundary");
   a_end_together: assert property ($fell(expose_out) |-> $fell(strobe_out))
      else $error("strobe and exposure ended apart");
   a_expose_min: assert property ($rose(expose_out) |=> expose_out[*8])
      else $error("exposure cut short");
   a_coll_busy: assert property (frame_start_collision_event |->
      $past(state_out) != TTED_IDLE)
      else $error("collision flagged while idle");
   a_coll_pulse: assert property (frame_start_collision_event |=>
      !frame_start_collision_event)
      else $error("collision pulse too long");
endmodule

// ==== dv/tted_far_model.sv ====
// trigger source and sensor row timing on the far side
`timescale 1ns/100ps
module tted_far_model #(
   parameter int ROW_CYC = 37
) (
   input wire logic core_clk, // core clock
   input wire logic arst_n, // async reset
   output logic trig_pin, // trigger pin
   output logic row_start // row boundary pulse
);
   int row_cnt;
   initial begin
      trig_pin = 1'b0;
      row_start = 1'b0;
      row_cnt = 0;
   end
   // two cycles wide so the sync flops cannot miss it
   always @(posedge core_clk) begin
      row_cnt <= (row_cnt == ROW_CYC - 1) ? 0 : row_cnt + 1;
      row_start <= (row_cnt < 2);
   end
   task pulse(input int w);
      @(posedge core_clk);
      trig_pin <= 1'b1;
      repeat (w) @(posedge core_clk);
      trig_pin <= 1'b0;
   endtask
endmodule

// ==== dv/tted_tb.sv ====
// self-checking bench of the trigger-to-exposure path
`timescale 1ns/100ps
`include "tted_consts.svh"
module tted_tb;
   import tted_pkg::*;
   logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic trig_pin, row_start, strobe_out, expose_out, coll, irq, seen;
   tted_state_t state_out;
   int err_count, comparisons, n1, n2, n3;

   tted_top u_tted_top (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trig_pin(trig_pin), .row_start(row_start), .strobe_out(strobe_out),
      .expose_out(expose_out), .state_out(state_out),
      .frame_start_collision_event(coll), .irq(irq));
   tted_far_model u_tted_far_model (.core_clk(core_clk), .arst_n(arst_n),
      .trig_pin(trig_pin), .row_start(row_start));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (strobe_out === 1'b1) seen <= 1'b1;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task end_sim;
      if (err_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rng(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic err);
      logic [31:0] q;
      logic e;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk({31'h0, e}, {31'h0, err});
      if (!w) chk(q, exp);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, exp, 1'b0);
   endtask
   task wait_sig(input int which, input logic v, output int n);
      n = 0;
      while (((which == 0) ? strobe_out : expose_out) !== v && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task chk_irq(input logic v);
      @(posedge core_clk);
      chk({31'h0, irq}, {31'h0, v});
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      end_sim;
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, seen} = '0;
      arst_n = 1'b0;
      err_count = 0;
      comparisons = 0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(`TTED_CTRL_OFF, 32'h1);
      rd(`TTED_EXPTIME_OFF, 32'h3E8);
      rd(`TTED_EXPDLY_OFF, 32'h0);
      rd(`TTED_MASK_OFF, 32'h0);
      rd(`TTED_IRQ_OFF, 32'h0);
      rd(`TTED_STATUS_OFF, 32'h0);
      apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b1);
      wr(`TTED_EXPDLY_OFF, 32'h1770);
      rd(`TTED_EXPDLY_OFF, 32'h1388);
      wr(`TTED_EXPDLY_OFF, 32'h1388);
      rd(`TTED_EXPDLY_OFF, 32'h1388);
      wr(`TTED_FILT_OFF, 32'h2);
      wr(`TTED_TRIGDLY_OFF, 32'h3);
      wr(`TTED_EXPDLY_OFF, 32'h2);
      wr(`TTED_EXPTIME_OFF, 32'h4);
      wr(`TTED_MASK_OFF, 32'h7);
      // a pulse shorter than the filter time must vanish
      u_tted_far_model.pulse(100);
      repeat (1000) @(posedge core_clk);
      chk({31'h0, seen}, 32'h0);
      fork u_tted_far_model.pulse(400); join_none
      wait_sig(0, 1'b1, n1);
      rng(n1, 500, 720);
      wait_sig(1, 1'b1, n2);
      rng(n2, 200, 380);
      // second trigger lands inside the running exposure
      fork u_tted_far_model.pulse(350); join_none
      wait_sig(1, 1'b0, n3);
      rng(n3, 400, 520);
      chk_irq(1'b1);
      rd(`TTED_IRQ_OFF, 32'h7);
      wr(`TTED_IRQ_OFF, 32'h1);
      rd(`TTED_IRQ_OFF, 32'h6);
      wr(`TTED_MASK_OFF, 32'h1);
      chk_irq(1'b0);
      wr(`TTED_IRQ_OFF, 32'h7);
      rd(`TTED_IRQ_OFF, 32'h0);
      // software trigger skips the filter
      wr(`TTED_CTRL_OFF, 32'h3);
      wr(`TTED_SWTRIG_OFF, 32'h1);
      wait_sig(0, 1'b1, n1);
      rng(n1, 290, 420);
      wait_sig(1, 1'b1, n2);
      rng(n2, 200, 380);
      wait_sig(1, 1'b0, n3);
      rng(n3, 400, 520);
      seen = 1'b0;
      wr(`TTED_CTRL_OFF, 32'h2);
      wr(`TTED_SWTRIG_OFF, 32'h1);
      repeat (600) @(posedge core_clk);
      chk({31'h0, seen}, 32'h0);
      end_sim;
   end
endmodule

bind tted_top tted_checker u_tted_checker (.core_clk(core_clk),
   .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .trig_pin(trig_pin), .row_start(row_start),
   .strobe_out(strobe_out), .expose_out(expose_out), .state_out(state_out),
   .frame_start_collision_event(frame_start_collision_event), .irq(irq));
